// ### dv/mdr_inst_model.sv
`timescale 1ns/1ps
// behavioural instrument seen through the link engine; answers fast, slow or not at all
module mdr_inst_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic mute,
  input wire mdr_pkg::mdr_req_t link_req,
  output mdr_pkg::mdr_rsp_t link_rsp,
  output logic link_timeout
);
  import mdr_pkg::*;
  logic [15:0] mem [0:255];
  logic [3:0] wait_q;
  mdr_req_t hold_q;

  // one request at a time; a released data bus toggles so stale values never look valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 4'h0;
      hold_q <= '0;
      link_rsp <= '0;
      link_timeout <= 1'b0;
    end else begin
      link_rsp.valid <= 1'b0;
      link_timeout <= 1'b0;
      if (link_req.valid) begin
        hold_q <= link_req;
        wait_q <= slow ? 4'h9 : 4'h2;
      end else if (wait_q == 4'h1) begin
        wait_q <= 4'h0;
        if (mute) begin
          link_timeout <= 1'b1; // silent line
        end else begin
          link_rsp.valid <= 1'b1;
          link_rsp.exception <= (hold_q.addr[15:8] != 8'h00);
          // whole 16-bit registers only
          link_rsp.data <= (hold_q.func == FC_WRITE) ? hold_q.data : mem[hold_q.addr[7:0]];
          if (hold_q.func == FC_WRITE) begin
            mem[hold_q.addr[7:0]] <= hold_q.data;
          end
        end
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else begin
        link_rsp.data <= ~link_rsp.data;
      end
    end
  end
endmodule

// ### dv/modbus_channel_diag_and_rw_relay_tb_top.sv
`timescale 1ns/1ps
module modbus_channel_diag_and_rw_relay_tb_top;
  import mdr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic slow = 1'b0;
  logic mute = 1'b0;
  logic link_timeout;
  logic [3:0] diag_flags;
  mdr_req_t link_req;
  mdr_rsp_t link_rsp;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] rnd = 16'hD564;
  logic [31:0] rd;
  logic [15:0] v;
  logic [15:0] old;
  logic [7:0] last_func = 8'h00;

  always #20 hclk = ~hclk;

  mdr_channel #(.POLL_CYCLES(20), .WARN_FAILS(2), .ERR_FAILS(8)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_req(link_req), .link_rsp(link_rsp),
    .link_timeout(link_timeout), .diag_flags(diag_flags)
  );

  mdr_inst_model inst_u (
    .hclk(hclk), .hresetn(hresetn), .slow(slow), .mute(mute), .link_req(link_req),
    .link_rsp(link_rsp), .link_timeout(link_timeout)
  );

  // remember which request the engine issued last, reads and writes alike
  always @(posedge hclk) begin
    if (link_req.valid === 1'b1) begin
      last_func <= link_req.func;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [31:0] relay_exp(input logic [15:0] r, input logic swap);
    return swap ? {16'h0000, r[7:0], r[15:8]} : {16'h0000, r};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // single word transfer; address phase held until hready, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_upd(input logic [1:0] s);
    for (int i = 0; i < 400; i++) begin
      xfer(1'b0, OFF_UPDATE, ZERO32);
      if (rd[1:0] === s) break;
    end
    chk(rd, {30'h0, s});
  endtask

  // hang guard well above the expected run length
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) inst_u.mem[i] = 16'h0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wait_upd(UPD_READY);
    $display("test startup done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      inst_u.mem[8'h10 + i] = rnd;
    end
    slow <= 1'b1;
    xfer(1'b1, OFF_RELAY_CFG, 32'h0003_0010);
    xfer(1'b1, OFF_UPDATE, {30'h0, UPD_BUSY});
    xfer(1'b0, OFF_UPDATE, ZERO32);
    chk(rd, {30'h0, UPD_READY});
    xfer(1'b1, OFF_UPDATE, {30'h0, UPD_REQ});
    wait_upd(UPD_BUSY);
    wait_upd(UPD_READY);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, OFF_RELAY_BASE + 8'(4 * i), ZERO32);
      chk(rd, relay_exp(inst_u.mem[8'h10 + i], 1'b0));
    end
    xfer(1'b1, OFF_UPDATE, {30'h0, UPD_NONE});
    xfer(1'b1, OFF_RELAY_CFG, 32'h0013_0010);
    xfer(1'b1, OFF_UPDATE, {30'h0, UPD_REQ});
    wait_upd(UPD_READY);
    xfer(1'b0, OFF_RELAY_BASE, ZERO32);
    chk(rd, relay_exp(inst_u.mem[8'h10], 1'b1));
    xfer(1'b1, OFF_UPDATE, {30'h0, UPD_NONE});
    xfer(1'b1, OFF_RELAY_CFG, 32'h0003_0010);
    slow <= 1'b0;
    $display("test readback done");
    rnd = lfsr(rnd);
    v = rnd;
    xfer(1'b1, OFF_RELAY_BASE + 8'h04, {16'h0000, v});
    for (int i = 0; i < 200 && inst_u.mem[8'h11] !== v; i++) @(posedge hclk);
    chk({16'h0000, inst_u.mem[8'h11]}, {16'h0000, v});
    // status 0x0050 under mask 0x00f0 gives flags 1 and 3 set
    inst_u.mem[8'h20] = 16'h0050;
    xfer(1'b1, OFF_EXCHANGE, 32'h00F0_0000);
    xfer(1'b1, OFF_STATUS_CFG, 32'h0001_0020);
    xfer(1'b1, OFF_DIAG_MASK, 32'h0400_0000);
    xfer(1'b1, OFF_DIAG_MAP, 32'h1202_1110);
    repeat (100) @(posedge hclk);
    chk({24'h0, last_func}, {24'h0, FC_INPUT});
    chk({28'h0, diag_flags}, 32'h0000_0001);
    xfer(1'b0, OFF_DIAG_OUT, ZERO32);
    chk({24'h0, rd[7:0]}, 32'h0000_0051);
    xfer(1'b0, OFF_EXCHANGE, ZERO32);
    chk(rd, 32'h00F0_0050);
    $display("test diag done");
    mute <= 1'b1;
    for (int i = 0; i < 100 && rd[8] !== 1'b1; i++) xfer(1'b0, OFF_DIAG_OUT, ZERO32);
    chk({29'h0, rd[10:8]}, 32'h0000_0003);
    mute <= 1'b0;
    xfer(1'b1, OFF_STATUS_CFG, 32'h0000_0120);
    repeat (100) @(posedge hclk);
    chk({24'h0, last_func}, {24'h0, FC_HOLDING});
    xfer(1'b0, OFF_DIAG_OUT, ZERO32);
    chk({31'h0, rd[10]}, 32'h0000_0001);
    xfer(1'b1, OFF_DIAG_MAP, 32'h1202_1610);
    repeat (5) @(posedge hclk);
    chk({28'h0, diag_flags}, 32'h0000_0003);
    $display("test supervision done");
    xfer(1'b1, OFF_CTRL, ZERO32);
    xfer(1'b1, OFF_DIAG_MAP, ZERO32);
    xfer(1'b0, OFF_DIAG_MAP, ZERO32);
    chk(rd, 32'h1202_1610);
    old = inst_u.mem[8'h10];
    xfer(1'b1, OFF_RELAY_BASE, {16'h0000, ~old});
    chk({31'h0, hresp}, ZERO32);
    xfer(1'b1, OFF_UPDATE, {30'h0, UPD_REQ});
    repeat (50) @(posedge hclk);
    chk({16'h0000, inst_u.mem[8'h10]}, {16'h0000, old});
    xfer(1'b0, OFF_UPDATE, ZERO32);
    chk(rd, {30'h0, UPD_NONE});
    slow <= 1'b1;
    xfer(1'b1, OFF_CTRL, 32'h0000_0001);
    xfer(1'b0, OFF_UPDATE, ZERO32);
    chk({31'h0, rd[1:0] == UPD_REQ || rd[1:0] == UPD_BUSY}, 32'h0000_0001);
    wait_upd(UPD_READY);
    $display("test mode change done");
    stop_test();
  end
endmodule

// ### rtl/mdr_channel.sv
`timescale 1ns/1ps
// Contract
// R1: fetch up to four diagnostic flags from one instrument status register
// R2: status read uses configured address and function code, input or holding
// R3: mask selects status bits, renumbered 1 to 4 keeping order
// R4: diagnostic settings accepted only while out of service
// R5: per category a map picks a flag and a mask blocks bits
// R6: a category mapping acts only when its priority is nonzero
// R7: supervision sets warning when unstable and error when stopped
// R8: exception replies set the configuration error flag
// R9: flags route onto fault, function check, maintenance, out of spec
// R10: relay block of up to ten registers from a start address and count
// R11: byte order 0 selects 1-0 default, 1 swaps to 0-1
// R12: host write to a relay value writes the instrument register
// R13: host requests read-back by writing 1 to update state
// R14: state holds 2 while the read-back is in progress
// R15: state goes to 3 once fresh values are ready
// R16: at start-up all configured relay registers are read
// R17: host writes only 0 or 1 to the update state
// R18: host ends read-back by writing 0, also when stuck at 2
// R19: relay and update writes refused unless out of service
// R20: on auto to out of service, re-read stepping 1, 2, 3
// R21: host should not leave state 3 after returning to auto
// R22: instrument registers are two bytes each
// R23: writes of 2 or 3 to the update state are ignored
module mdr_channel #(
  parameter int POLL_CYCLES = 2500,
  parameter int WARN_FAILS = 2,
  parameter int ERR_FAILS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output mdr_pkg::mdr_req_t link_req,
  input wire mdr_pkg::mdr_rsp_t link_rsp,
  input wire logic link_timeout,
  output logic [3:0] diag_flags
);
  import mdr_pkg::*;

  typedef enum {S_IDLE, S_STATUS, S_READ, S_WRITE, S_WAIT} mdr_state_t;

  // control: bit0 out_of_service_mode
  logic oos_q;
  logic [15:0] status_addr_q;
  logic status_input_q;
  logic [15:0] status_mask_q;
  logic [31:0] diag_map_q;   // 4 x {prio[3:0], map[3:0]}
  logic [31:0] diag_mask_q;  // 4 x 8 source mask
  logic [15:0] relay_start_q;
  logic [3:0] relay_block_count_q;
  logic order_swap_q;
  logic [1:0] upd_q;
  logic [15:0] relay_q [RELAY_MAX];
  logic [RELAY_MAX-1:0] wr_pend_q;
  logic [15:0] status_val_q;
  logic comm_warn_q, comm_err_q, cfg_err_q;
  logic [3:0] fail_cnt_q;
  logic [31:0] poll_cnt_q;
  mdr_state_t st_q;
  mdr_state_t ret_q;
  logic [3:0] idx_q;
  logic rb_run_q;

  // ahb address phase capture
  logic ap_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  wire take = hsel && hready && htrans[1];
  wire wr_en = ap_q && ap_wr_q;

  function automatic logic [15:0] swap16(input logic [15:0] v, input logic s);
    swap16 = s ? {v[7:0], v[15:8]} : v; // R11 R22
  endfunction

  function automatic logic [3:0] compact(input logic [15:0] v, input logic [15:0] m);
    logic [3:0] r;
    int n;
    r = 4'h0;
    n = 0;
    for (int i = 0; i < 16; i++) begin
      if (m[i] && n < FLAG_N) begin
        r[n[1:0]] = v[i]; // R3
        n++;
      end
    end
    compact = r;
  endfunction

  wire [3:0] flags = compact(status_val_q, status_mask_q); // R1
  // sources: flags 1..4, comm error, comm warning, config error, unused
  wire [7:0] src = {1'b0, cfg_err_q, comm_warn_q, comm_err_q, flags}; // R9

  // bus address phase, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_q <= take;
      ap_wr_q <= take && hwrite;
      if (take) ap_addr_q <= haddr[7:0];
    end
  end

  wire relay_hit = ap_addr_q >= OFF_RELAY_BASE &&
                   ap_addr_q < OFF_RELAY_BASE + 8'(4 * RELAY_MAX);
  wire [3:0] relay_idx = 4'((ap_addr_q - OFF_RELAY_BASE) >> 2);

  // mode and configuration; out-of-service gates every setting except the mode bit in OFF_CTRL
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oos_q <= 1'b1;
      status_addr_q <= 16'h0000;
      status_input_q <= 1'b0;
      status_mask_q <= STATUS_MASK_RST;
      diag_map_q <= ZERO32;
      diag_mask_q <= ZERO32;
      relay_start_q <= 16'h0000;
      relay_block_count_q <= 4'h0;
      order_swap_q <= 1'b0; // R11
    end else if (wr_en) begin
      if (ap_addr_q == OFF_CTRL) oos_q <= hwdata[0];
      if (oos_q) begin // R4
        unique case (ap_addr_q)
          OFF_STATUS_CFG: begin
            status_addr_q <= hwdata[15:0]; // R2
            status_input_q <= hwdata[16];
          end
          OFF_DIAG_MAP: diag_map_q <= hwdata; // R5
          OFF_DIAG_MASK: diag_mask_q <= hwdata; // R5
          OFF_RELAY_CFG: begin
            relay_start_q <= hwdata[15:0]; // R10
            relay_block_count_q <= hwdata[19:16] > 4'(RELAY_MAX) ? 4'(RELAY_MAX)
                                                            : hwdata[19:16];
            order_swap_q <= hwdata[20]; // R11
          end
          OFF_EXCHANGE: status_mask_q <= hwdata[31:16];
          default: ;
        endcase
      end
    end
  end

  // entry to out of service from auto
  wire go_oos = wr_en && ap_addr_q == OFF_CTRL && hwdata[0] && !oos_q;
  wire host_upd = wr_en && oos_q && ap_addr_q == OFF_UPDATE;

  // read-back state machine of the update parameter
  logic start_up_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_q <= UPD_NONE;
      start_up_q <= 1'b1;
    end else begin
      start_up_q <= 1'b0;
      if (go_oos || start_up_q) begin
        upd_q <= UPD_REQ; // R16 R20
      end else if (st_q == S_IDLE && upd_q == UPD_REQ && !rb_run_q) begin
        upd_q <= UPD_BUSY; // R14
      end else if (rb_run_q && st_q == S_IDLE && idx_q >= relay_block_count_q &&
                   upd_q == UPD_BUSY) begin
        // only from busy, so a host write of 0 or 1 before the run's completing cycle is not overtaken; one landing in that cycle is lost
        upd_q <= UPD_READY; // R15
      end else if (host_upd && hwdata[1:0] <= UPD_REQ) begin
        upd_q <= hwdata[1:0]; // R13 R18 R23
      end
    end
  end

  // relay values, host writes and pending write flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < RELAY_MAX; i++) relay_q[i] <= 16'h0000;
      wr_pend_q <= '0;
    end else begin
      // engine side first, host side last: a host write landing with a completion wins
      if (st_q == S_WAIT && link_rsp.valid && ret_q == S_READ && !wr_pend_q[idx_q]) begin
        relay_q[idx_q] <= swap16(link_rsp.data, order_swap_q); // keep unsent host values
      end
      if (st_q == S_WAIT && (link_rsp.valid || link_timeout) && ret_q == S_WRITE) begin
        wr_pend_q[idx_q] <= 1'b0;
      end
      if (wr_en && oos_q && relay_hit && relay_idx < relay_block_count_q) begin // R19
        relay_q[relay_idx] <= hwdata[15:0];
        wr_pend_q[relay_idx] <= 1'b1; // R12
      end
    end
  end

  // link engine: poll status, relay writes, read-backs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      ret_q <= S_IDLE;
      idx_q <= 4'h0;
      rb_run_q <= 1'b0;
      poll_cnt_q <= 32'h0000_0000;
      link_req <= '0;
    end else begin
      link_req.valid <= 1'b0;
      if (poll_cnt_q != 32'h0000_0000) poll_cnt_q <= poll_cnt_q - 32'h0000_0001;
      unique case (st_q)
        S_IDLE: begin
          if (upd_q == UPD_BUSY && !rb_run_q) begin
            rb_run_q <= 1'b1;
            idx_q <= 4'h0;
          end else if (rb_run_q && idx_q < relay_block_count_q) begin
            link_req <= '{1'b1, FC_HOLDING, relay_start_q + 16'(idx_q), 16'h0000};
            ret_q <= S_READ;
            st_q <= S_WAIT;
          end else if (rb_run_q) begin
            rb_run_q <= 1'b0;
          end else if (|wr_pend_q) begin
            for (int i = RELAY_MAX - 1; i >= 0; i--) begin
              if (wr_pend_q[i]) idx_q <= 4'(i);
            end
            st_q <= S_WRITE;
          end else if (poll_cnt_q == 32'h0000_0000) begin
            link_req <= '{1'b1, status_input_q ? FC_INPUT : FC_HOLDING, // R2
                          status_addr_q, 16'h0000};
            ret_q <= S_STATUS;
            st_q <= S_WAIT;
          end
        end
        S_WRITE: begin
          link_req <= '{1'b1, FC_WRITE, relay_start_q + 16'(idx_q), // R12
                        swap16(relay_q[idx_q], order_swap_q)};
          ret_q <= S_WRITE;
          st_q <= S_WAIT;
        end
        S_WAIT: begin
          if (link_rsp.valid || link_timeout) begin
            st_q <= S_IDLE;
            if (ret_q == S_READ) idx_q <= idx_q + 4'h1;
            if (ret_q == S_STATUS) poll_cnt_q <= 32'(POLL_CYCLES);
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // status capture and communication supervision
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_val_q <= 16'h0000;
      fail_cnt_q <= 4'h0;
      comm_warn_q <= 1'b0;
      comm_err_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else if (st_q == S_WAIT) begin
      if (link_rsp.valid) begin
        fail_cnt_q <= 4'h0;
        comm_warn_q <= 1'b0;
        comm_err_q <= 1'b0;
        cfg_err_q <= link_rsp.exception; // R8
        if (ret_q == S_STATUS && !link_rsp.exception) begin
          status_val_q <= swap16(link_rsp.data, order_swap_q); // R22
        end
      end else if (link_timeout) begin
        if (fail_cnt_q != 4'hf) fail_cnt_q <= fail_cnt_q + 4'h1;
        if (fail_cnt_q + 4'h1 >= 4'(WARN_FAILS)) comm_warn_q <= 1'b1; // R7
        if (fail_cnt_q + 4'h1 >= 4'(ERR_FAILS)) comm_err_q <= 1'b1; // R7
      end
    end
  end

  // category outputs: fault, function check, maintenance, out of spec
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_flags <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        logic [3:0] sel;
        logic [3:0] prio;
        logic [7:0] msk;
        sel = diag_map_q[8*c +: 4];
        prio = diag_map_q[8*c+4 +: 4];
        msk = diag_mask_q[8*c +: 8];
        diag_flags[c] <= prio != 4'h0 && sel < 4'h8 && // R6
                         src[sel[2:0]] && !msk[sel[2:0]]; // R5 R9
      end
    end
  end

  // bus read data, decoded in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= ZERO32;
    end else if (take && !hwrite) begin
      hrdata <= ZERO32;
      if (haddr[7:0] >= OFF_RELAY_BASE &&
          haddr[7:0] < OFF_RELAY_BASE + 8'(4 * RELAY_MAX)) begin
        hrdata <= {16'h0000, relay_q[4'((haddr[7:0] - OFF_RELAY_BASE) >> 2)]};
      end else begin
        unique case (haddr[7:0])
          OFF_CTRL: hrdata <= {31'h0000_0000, oos_q};
          OFF_STATUS_CFG: hrdata <= {15'h0000, status_input_q, status_addr_q};
          OFF_DIAG_MAP: hrdata <= diag_map_q;
          OFF_DIAG_MASK: hrdata <= diag_mask_q;
          OFF_RELAY_CFG: hrdata <= {11'h000, order_swap_q, relay_block_count_q,
                                    relay_start_q};
          OFF_UPDATE: hrdata <= {30'h0000_0000, upd_q};
          OFF_DIAG_OUT: hrdata <= {21'h00_0000, cfg_err_q, comm_warn_q, comm_err_q,
                                   flags, diag_flags};
          OFF_EXCHANGE: hrdata <= {status_mask_q, status_val_q};
          default: hrdata <= ZERO32;
        endcase
      end
    end
  end

  // always ready and okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read-back state must pass through busy before ready
  ready_after_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(upd_q) && upd_q == UPD_READY |-> $past(upd_q) == UPD_BUSY) // R15
    else $error("update state reached ready without busy");
  bad_value_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
    host_upd && hwdata[1] && upd_q != UPD_REQ && !rb_run_q
    |=> upd_q == $past(upd_q)) // R23
    else $error("write of 2 or 3 changed update state");
  oos_gate_cfg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oos_q |=> $stable(diag_map_q) && $stable(status_mask_q)) // R4
    else $error("diagnostic settings changed in auto");
  oos_gate_relay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !oos_q && !$past(wr_pend_q[0]) |=> !wr_pend_q[0] || $past(wr_pend_q[0])) // R19
    else $error("relay write accepted in auto");
  req_to_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    upd_q == UPD_REQ && st_q == S_IDLE && !rb_run_q && !go_oos |=> upd_q == UPD_BUSY) // R14
    else $error("request did not move to busy");
  auto_to_oos_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go_oos |=> upd_q == UPD_REQ) // R20
    else $error("mode change did not start read-back");
  prio_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    diag_map_q[7:4] == 4'h0 && $past(diag_map_q[7:4]) == 4'h0 |=> !diag_flags[0]) // R6
    else $error("category raised without priority");
  cfg_err_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == S_WAIT && link_rsp.valid && link_rsp.exception |=> cfg_err_q) // R8
    else $error("exception did not set config error");
  status_fc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    link_req.valid && ret_q == S_STATUS |->
    link_req.func == (status_input_q ? FC_INPUT : FC_HOLDING)) // R2
    else $error("status read used wrong function code");
  // an accepted write to relay 1 is always queued, even as an older one completes
  host_relay_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && oos_q && relay_hit && relay_idx == 4'h1 && relay_block_count_q > 4'h1
    |=> wr_pend_q[1]) // R12
    else $error("host relay write not queued for the instrument");
  // update writes in auto leave the idle state alone
  upd_auto_refused_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && !oos_q && ap_addr_q == OFF_UPDATE && upd_q == UPD_NONE
    |=> upd_q == UPD_NONE) // R19
    else $error("update state written in auto");
endmodule

// ### rtl/mdr_pkg.sv
package mdr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS_CFG = 8'h04;
  localparam logic [7:0] OFF_DIAG_MAP = 8'h08;
  localparam logic [7:0] OFF_DIAG_MASK = 8'h0C;
  localparam logic [7:0] OFF_RELAY_CFG = 8'h10;
  localparam logic [7:0] OFF_UPDATE = 8'h14;
  localparam logic [7:0] OFF_DIAG_OUT = 8'h18;
  localparam logic [7:0] OFF_EXCHANGE = 8'h1C;
  localparam logic [7:0] OFF_RELAY_BASE = 8'h40;
  localparam int RELAY_MAX = 10;
  localparam int FLAG_N = 4;
  // read-back states
  localparam logic [1:0] UPD_NONE = 2'd0;
  localparam logic [1:0] UPD_REQ = 2'd1;
  localparam logic [1:0] UPD_BUSY = 2'd2;
  localparam logic [1:0] UPD_READY = 2'd3;
  // instrument function codes
  localparam logic [7:0] FC_HOLDING = 8'h03;
  localparam logic [7:0] FC_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE = 8'h06;
  // reset values
  localparam logic [15:0] STATUS_MASK_RST = 16'h0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // request to the instrument link engine
  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } mdr_req_t;

  // reply from the instrument link engine
  typedef struct packed {
    logic valid;
    logic exception;
    logic [15:0] data;
  } mdr_rsp_t;
endpackage
